// ### bench/sbs_ctrl_model.sv
// scan controller model that drives the four-wire test link
`timescale 1ns/1ns
module sbs_ctrl_model (
   input wire logic sys_clk_i,
   input wire logic tdo_i,
   input wire logic tdo_oe_n_i,
   output logic tck_o,
   output logic tms_o,
   output logic tms_oe_n_o,
   output logic tdi_o,
   output logic tdi_oe_n_o
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tms_oe_n_o = 1'b0;
      tdi_o = 1'b1;
      tdi_oe_n_o = 1'b0;
   end
   // one 160 ns test clock period, tdo taken just before the rise
   task automatic bit_io(input logic tms, input logic tdi, input logic rel,
         output logic tdo, output logic tdo_oe_n);
      @(negedge sys_clk_i);
      tms_oe_n_o = rel;
      tdi_oe_n_o = rel;
      tms_o = rel ? ~tms_o : tms;
      tdi_o = rel ? ~tdi_o : tdi;
      repeat (3) @(negedge sys_clk_i);
      tdo = tdo_i;
      tdo_oe_n = tdo_oe_n_i;
      tck_o = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      tck_o = 1'b0;
   endtask : bit_io
   // mode line moves while the test clock stands still
   task automatic wiggle(input int n);
      repeat (n) begin
         @(negedge sys_clk_i);
         tms_o = ~tms_o;
      end
   endtask : wiggle
endmodule : sbs_ctrl_model

// ### bench/sbs_tap_tb_top.sv
// self-checking bench for the boundary scan test port
`timescale 1ns/1ns
module sbs_tap_tb_top;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [sbs_pkg::BSR_W-1:0] ring = '0;
   logic tck, tms, tms_oe_n, tdi, tdi_oe_n, tdo, tdo_oe_n, hiz, oe;
   logic [2:0] instr;
   logic [2:0] cur;
   logic [255:0] dout;
   int n_mismatch = 0;
   int compares = 0;
   sbs_tap u_sbs_tap (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .tck_i(tck), .tms_i(tms), .tms_oe_n_i(tms_oe_n), .tdi_i(tdi),
      .tdi_oe_n_i(tdi_oe_n), .ring_i(ring), .tdo_o(tdo),
      .tdo_oe_n_o(tdo_oe_n), .outputs_hiz_o(hiz), .instr_o(instr));
   sbs_ctrl_model u_sbs_ctrl_model (.sys_clk_i(sys_clk_i), .tdo_i(tdo),
      .tdo_oe_n_i(tdo_oe_n), .tck_o(tck), .tms_o(tms),
      .tms_oe_n_o(tms_oe_n), .tdi_o(tdi), .tdi_oe_n_o(tdi_oe_n));
   initial begin
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   task automatic cmp(input logic [255:0] got, input logic [255:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic walk(input logic [7:0] seq, input int n, input logic rel);
      logic t, o;
      for (int i = 0; i < n; i++) begin
         u_sbs_ctrl_model.bit_io(seq[i], 1'b1, rel, t, o);
      end
   endtask : walk
   // shift n bits, then update and idle
   task automatic shift(input int n, input logic [255:0] din);
      logic o;
      dout = '0;
      oe = 1'b0;
      for (int i = 0; i < n; i++) begin
         u_sbs_ctrl_model.bit_io(i == n - 1, din[i], 1'b0, dout[i], o);
         oe = oe | o;
      end
      walk(8'h01, 2, 1'b0);
      cmp(tdo_oe_n, 1'b1);
      cmp(oe, 1'b0);
   endtask : shift
   task automatic load_ir(input logic [2:0] code);
      walk(8'h03, 4, 1'b0);
      shift(3, {253'h0, code});
      cmp(dout[2:0], {cur[2], sbs_pkg::IR_CAPTURE_LSB});
      cmp(instr, code);
      cur = code;
   endtask : load_ir
   task automatic dr_check(input int n, input logic [255:0] cap,
         input logic [255:0] din);
      logic [255:0] exp;
      exp = cap;
      for (int i = 0; i < n; i++) begin
         exp[n + i] = din[i];
      end
      walk(8'h01, 3, 1'b0);
      shift(2 * n, din);
      cmp(dout, exp);
   endtask : dr_check
   task automatic t_codes();
      logic [2:0] codes [4];
      codes = '{sbs_pkg::INS_SAMPLE_Z, sbs_pkg::INS_SAMPLE,
         sbs_pkg::INS_EXTEST, sbs_pkg::INS_BYPASS};
      walk(8'h1F, 6, 1'b0);
      cur = sbs_pkg::IR_RESET;
      foreach (codes[k]) begin
         load_ir(codes[k]);
         repeat (4) @(negedge sys_clk_i);
         cmp(hiz, codes[k] == sbs_pkg::INS_SAMPLE_Z);
      end
   endtask : t_codes
   task automatic t_dr();
      walk(8'h1F, 6, 1'b0);
      cur = sbs_pkg::IR_RESET;
      u_sbs_ctrl_model.wiggle(40);
      dr_check(32, sbs_pkg::ID_CODE, 256'h5A3C_96E1);
      ring = {11'h5A3, 32'hDEAD_0F0F, 64'h0123_4567_89AB_CDEF};
      load_ir(sbs_pkg::INS_SAMPLE);
      dr_check(sbs_pkg::BSR_W, ring, ~ring);
      load_ir(3'h5);
      dr_check(1, 256'h0, 256'h1);
      load_ir(sbs_pkg::INS_BYPASS);
      dr_check(1, 256'h0, 256'h1);
   endtask : t_dr
   // released mode line reads high, reset needs the fifth rise
   task automatic t_rst5();
      walk(8'h01, 3, 1'b0);
      walk(8'h0F, 4, 1'b1);
      cmp(instr, sbs_pkg::INS_BYPASS);
      walk(8'h01, 1, 1'b1);
      cmp(instr, sbs_pkg::IR_RESET);
   endtask : t_rst5
   task automatic finish_test();
      $display("n_mismatch %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (12) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      cmp(instr, sbs_pkg::IR_RESET);
      cmp(tdo_oe_n, 1'b1);
      cmp(hiz, 1'b0);
      t_codes();
      t_dr();
      t_rst5();
      finish_test();
   end
   // run needs about 3150 cycles
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      n_mismatch++;
      finish_test();
   end
endmodule : sbs_tap_tb_top

// ### verilog/sbs_fsm.sv
// test port controller state machine
`timescale 1ns/1ns
module sbs_fsm (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic rise_i,
   input wire logic tms_i,
   output sbs_pkg::sbs_state_type state_o
);
   sbs_pkg::sbs_state_type state_r;
   sbs_pkg::sbs_state_type state_nxt;

   // sixteen states, stepped only on a test clock rising edge
   always_comb begin
      state_nxt = state_r;
      if (rise_i) begin
         case (state_r)
            sbs_pkg::ST_RESET:
               state_nxt = tms_i ? sbs_pkg::ST_RESET : sbs_pkg::ST_IDLE;
            sbs_pkg::ST_IDLE:
               state_nxt = tms_i ? sbs_pkg::ST_SEL_DR : sbs_pkg::ST_IDLE;
            sbs_pkg::ST_SEL_DR:
               state_nxt = tms_i ? sbs_pkg::ST_SEL_IR : sbs_pkg::ST_CAP_DR;
            sbs_pkg::ST_CAP_DR:
               state_nxt = tms_i ? sbs_pkg::ST_EXIT1_DR : sbs_pkg::ST_SHIFT_DR;
            sbs_pkg::ST_SHIFT_DR:
               state_nxt = tms_i ? sbs_pkg::ST_EXIT1_DR : sbs_pkg::ST_SHIFT_DR;
            sbs_pkg::ST_EXIT1_DR:
               state_nxt = tms_i ? sbs_pkg::ST_UPD_DR : sbs_pkg::ST_PAUSE_DR;
            sbs_pkg::ST_PAUSE_DR:
               state_nxt = tms_i ? sbs_pkg::ST_EXIT2_DR : sbs_pkg::ST_PAUSE_DR;
            sbs_pkg::ST_EXIT2_DR:
               state_nxt = tms_i ? sbs_pkg::ST_UPD_DR : sbs_pkg::ST_SHIFT_DR;
            sbs_pkg::ST_UPD_DR:
               state_nxt = tms_i ? sbs_pkg::ST_SEL_DR : sbs_pkg::ST_IDLE;
            sbs_pkg::ST_SEL_IR:
               state_nxt = tms_i ? sbs_pkg::ST_RESET : sbs_pkg::ST_CAP_IR;
            sbs_pkg::ST_CAP_IR:
               state_nxt = tms_i ? sbs_pkg::ST_EXIT1_IR : sbs_pkg::ST_SHIFT_IR;
            sbs_pkg::ST_SHIFT_IR:
               state_nxt = tms_i ? sbs_pkg::ST_EXIT1_IR : sbs_pkg::ST_SHIFT_IR;
            sbs_pkg::ST_EXIT1_IR:
               state_nxt = tms_i ? sbs_pkg::ST_UPD_IR : sbs_pkg::ST_PAUSE_IR;
            sbs_pkg::ST_PAUSE_IR:
               state_nxt = tms_i ? sbs_pkg::ST_EXIT2_IR : sbs_pkg::ST_PAUSE_IR;
            sbs_pkg::ST_EXIT2_IR:
               state_nxt = tms_i ? sbs_pkg::ST_UPD_IR : sbs_pkg::ST_SHIFT_IR;
            sbs_pkg::ST_UPD_IR:
               state_nxt = tms_i ? sbs_pkg::ST_SEL_DR : sbs_pkg::ST_IDLE;
            default:
               state_nxt = sbs_pkg::ST_RESET;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_r <= sbs_pkg::ST_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign state_o = state_r;

   stay_still_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !rise_i |=> state_r == $past(state_r))
      else $error("state moved without a test clock rise");
   sel_ir_exit_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      rise_i && tms_i && state_r == sbs_pkg::ST_SEL_IR
      |=> state_r == sbs_pkg::ST_RESET)
      else $error("select-ir with tms high did not reach reset");
endmodule : sbs_fsm

// ### verilog/sbs_pkg.sv
// constants and carrier types for the sram boundary scan test port
package sbs_pkg;
   localparam int IR_W = 3;
   localparam int BSR_W = 107;
   localparam int ID_W = 32;
   localparam int RESET_TMS_EDGES = 5;
   // instruction codes
   localparam logic [2:0] INS_EXTEST = 3'h0;
   localparam logic [2:0] INS_IDCODE = 3'h1;
   localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
   localparam logic [2:0] INS_SAMPLE = 3'h4;
   localparam logic [2:0] INS_BYPASS = 3'h7;
   localparam logic [2:0] IR_RESET = INS_IDCODE;
   localparam logic [1:0] IR_CAPTURE_LSB = 2'h1;
   // identification word, value arbitrary
   localparam logic [31:0] ID_CODE = 32'h0000_0001;

   typedef enum {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
      ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
      ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
   } sbs_state_type;

   // sampled link inputs
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } sbs_link_type;
endpackage : sbs_pkg

// ### verilog/sbs_tap.sv
// sram boundary scan test access port
// Behaviour
// - controller plus ir, boundary, bypass, id registers
// - inputs sampled on test clock rise only
// - tdo and outputs_hiz_o change on test clock fall only
// - tms level at rise picks the transition
// - still test clock never advances controller
// - undriven tdi and tms read high
// - controller starts in reset without help
// - coexists with compliant ports on shared chain
// - five tms-high rises reach reset state
// - three-bit ir loads id instruction on reset
// - capture-ir loads 01 into low bits
// - shift in at msb, out at lsb
`timescale 1ns/1ns
module sbs_tap (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tms_oe_n_i,
   input wire logic tdi_i,
   input wire logic tdi_oe_n_i,
   input wire logic [sbs_pkg::BSR_W-1:0] ring_i,
   output logic tdo_o,
   output logic tdo_oe_n_o,
   output logic outputs_hiz_o,
   output logic [sbs_pkg::IR_W-1:0] instr_o
);
   sbs_pkg::sbs_link_type meta_r, sync_r, link_nxt, link_r;
   logic rise, fall;
   sbs_pkg::sbs_state_type state;
   logic [sbs_pkg::BSR_W-1:0] ring_meta_r, ring_sync_r;

   // pull-ups: an undriven pin (enable high) reads as one
   always_comb begin
      link_nxt.tck = tck_i;
      link_nxt.tms = tms_oe_n_i ? 1'b1 : tms_i;
      link_nxt.tdi = tdi_oe_n_i ? 1'b1 : tdi_i;
   end

   // two-stage synchroniser, then an edge history stage
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         meta_r <= 3'h3;
         sync_r <= 3'h3;
         link_r <= 3'h3;
         ring_meta_r <= '0;
         ring_sync_r <= '0;
      end else begin
         meta_r <= link_nxt;
         sync_r <= meta_r;
         link_r <= sync_r;
         ring_meta_r <= ring_i;
         ring_sync_r <= ring_meta_r;
      end
   end

   assign rise = sync_r.tck & ~link_r.tck;
   assign fall = ~sync_r.tck & link_r.tck;

   sbs_fsm u_fsm (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .rise_i(rise),
      .tms_i(sync_r.tms),
      .state_o(state)
   );

   logic [sbs_pkg::IR_W-1:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
   logic [sbs_pkg::BSR_W-1:0] bsr_r, bsr_nxt;
   logic [sbs_pkg::ID_W-1:0] id_r, id_nxt;
   logic byp_r, byp_nxt;
   logic tdo_nxt, tdo_oe_n_nxt, hiz_nxt;
   logic [2:0] tms_cnt_r, tms_cnt_nxt;

   function automatic logic is_bsr(input logic [2:0] ins);
      is_bsr = ins == sbs_pkg::INS_EXTEST || ins == sbs_pkg::INS_SAMPLE_Z
         || ins == sbs_pkg::INS_SAMPLE;
   endfunction : is_bsr

   // register capture and shift on rise, output on fall
   always_comb begin
      ir_sh_nxt = ir_sh_r;
      ir_nxt = ir_r;
      bsr_nxt = bsr_r;
      id_nxt = id_r;
      byp_nxt = byp_r;
      tdo_nxt = tdo_o;
      tdo_oe_n_nxt = tdo_oe_n_o;
      hiz_nxt = outputs_hiz_o;
      tms_cnt_nxt = tms_cnt_r;
      if (rise) begin
         tms_cnt_nxt = !sync_r.tms ? 3'h0 :
            (tms_cnt_r == 3'(sbs_pkg::RESET_TMS_EDGES) ? tms_cnt_r :
             tms_cnt_r + 3'h1);
         case (state)
            sbs_pkg::ST_RESET: begin
               ir_nxt = sbs_pkg::IR_RESET;
            end
            sbs_pkg::ST_CAP_IR: begin
               ir_sh_nxt = {ir_r[2], sbs_pkg::IR_CAPTURE_LSB};
            end
            sbs_pkg::ST_SHIFT_IR: begin
               ir_sh_nxt = {sync_r.tdi, ir_sh_r[2:1]};
            end
            sbs_pkg::ST_UPD_IR: begin
               ir_nxt = ir_sh_r;
            end
            sbs_pkg::ST_CAP_DR: begin
               if (ir_r == sbs_pkg::INS_IDCODE) id_nxt = sbs_pkg::ID_CODE;
               else if (is_bsr(ir_r)) bsr_nxt = ring_sync_r;
               else byp_nxt = 1'b0;
            end
            sbs_pkg::ST_SHIFT_DR: begin
               if (ir_r == sbs_pkg::INS_IDCODE)
                  id_nxt = {sync_r.tdi, id_r[sbs_pkg::ID_W-1:1]};
               else if (is_bsr(ir_r))
                  bsr_nxt = {sync_r.tdi, bsr_r[sbs_pkg::BSR_W-1:1]};
               else
                  byp_nxt = sync_r.tdi;
            end
            default: begin
            end
         endcase
      end
      if (fall) begin
         tdo_oe_n_nxt = !(state == sbs_pkg::ST_SHIFT_IR
            || state == sbs_pkg::ST_SHIFT_DR);
         if (state == sbs_pkg::ST_SHIFT_IR) tdo_nxt = ir_sh_r[0];
         else if (ir_r == sbs_pkg::INS_IDCODE) tdo_nxt = id_r[0];
         else if (is_bsr(ir_r)) tdo_nxt = bsr_r[0];
         else tdo_nxt = byp_r;
         hiz_nxt = ir_r == sbs_pkg::INS_SAMPLE_Z;
      end
      // id instruction held while the controller rests in reset
      if (state == sbs_pkg::ST_RESET) begin
         ir_nxt = sbs_pkg::IR_RESET;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ir_sh_r <= sbs_pkg::IR_RESET;
         ir_r <= sbs_pkg::IR_RESET;
         bsr_r <= '0;
         id_r <= '0;
         byp_r <= 1'b0;
         tdo_o <= 1'b1;
         tdo_oe_n_o <= 1'b1;
         outputs_hiz_o <= 1'b0;
         tms_cnt_r <= 3'h0;
      end else begin
         ir_sh_r <= ir_sh_nxt;
         ir_r <= ir_nxt;
         bsr_r <= bsr_nxt;
         id_r <= id_nxt;
         byp_r <= byp_nxt;
         tdo_o <= tdo_nxt;
         tdo_oe_n_o <= tdo_oe_n_nxt;
         outputs_hiz_o <= hiz_nxt;
         tms_cnt_r <= tms_cnt_nxt;
      end
   end

   assign instr_o = ir_r;

   five_high_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      tms_cnt_r == 3'(sbs_pkg::RESET_TMS_EDGES)
      |-> state == sbs_pkg::ST_RESET)
      else $error("five tms high rises without reset state");
   tdo_fall_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !fall |=> $stable(tdo_o) && $stable(tdo_oe_n_o))
      else $error("tdo changed away from a test clock fall");
   tdo_shift_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !tdo_oe_n_o |-> $past(state) == sbs_pkg::ST_SHIFT_IR
      || $past(state) == sbs_pkg::ST_SHIFT_DR || !$past(fall))
      else $error("tdo enabled outside a shift state");
   tdo_off_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      fall && state != sbs_pkg::ST_SHIFT_IR && state != sbs_pkg::ST_SHIFT_DR
      |=> tdo_oe_n_o)
      else $error("tdo left driven outside a shift state");
   tdo_lsb_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      fall && state == sbs_pkg::ST_SHIFT_IR |=> tdo_o == $past(ir_sh_r[0]))
      else $error("tdo not taken from the lsb");
   reset_ir_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      state == sbs_pkg::ST_RESET |=> ir_r == sbs_pkg::IR_RESET)
      else $error("instruction not reloaded in reset state");
   cap_ir_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      rise && state == sbs_pkg::ST_CAP_IR
      |=> ir_sh_r[1:0] == sbs_pkg::IR_CAPTURE_LSB)
      else $error("capture did not load 01");
   shift_in_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      rise && state == sbs_pkg::ST_SHIFT_IR
      |=> ir_sh_r[2] == $past(sync_r.tdi))
      else $error("serial input not at msb");
   id_cap_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      rise && state == sbs_pkg::ST_CAP_DR && ir_r == sbs_pkg::INS_IDCODE
      |=> id_r == sbs_pkg::ID_CODE)
      else $error("id word not captured");
   bsr_cap_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      rise && state == sbs_pkg::ST_CAP_DR && is_bsr(ir_r)
      |=> bsr_r == $past(ring_sync_r))
      else $error("pin ring not captured");
   byp_cap_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      rise && state == sbs_pkg::ST_CAP_DR && ir_r == sbs_pkg::INS_BYPASS
      |=> !byp_r)
      else $error("bypass bit not cleared on capture");
   rise_only_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !rise |=> $stable(ir_sh_r) && $stable(byp_r))
      else $error("register moved without a test clock rise");
   pullup_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      tms_oe_n_i |-> ##2 sync_r.tms)
      else $error("undriven tms not read high");
   tdi_pullup_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      tdi_oe_n_i |-> ##2 sync_r.tdi)
      else $error("undriven tdi not read high");
endmodule : sbs_tap
